// [csx_aux_status.sv]
// Auxiliary status register: registered snapshot of the status sources
`timescale 1ns/100ps
module csx_aux_status (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic set_default,
   // Status sources
   input wire logic channel_pm,
   input wire logic field_detected,
   input wire logic tx_active,
   input wire logic osc_running,
   input wire logic osc_stable,
   input wire logic rx_enabled,
   input wire logic rx_busy,
   input wire logic peer_detect_active,
   input wire logic collision_avoid_active,
   // Register value
   output logic [7:0] aux_ff
);
   logic [7:0] nxt_aux;

   always_comb begin
      nxt_aux[7] = channel_pm;
      nxt_aux[6] = field_detected;
      nxt_aux[5] = tx_active;
      nxt_aux[4] = osc_running & osc_stable;
      nxt_aux[3] = rx_enabled;
      nxt_aux[2] = rx_busy;
      nxt_aux[1] = peer_detect_active;
      nxt_aux[0] = collision_avoid_active;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n || set_default) begin
         aux_ff <= csx_pkg::CSX_RST_DISPLAY;
      end else begin
         aux_ff <= nxt_aux;
      end
   end
endmodule // csx_aux_status

// [csx_host.sv]
// Host model issuing register strobes at the falling edge
`timescale 1ns/100ps
module csx_host (
   input wire logic clk_sys, reg_rvalid_ff,
   input wire logic [7:0] reg_rdata_ff,
   output logic reg_wr = 0, reg_rd = 0,
   output logic [7:0] reg_addr = 0, reg_wdata = 0
);
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge clk_sys);
      reg_wr = 0;
      reg_wdata = ~d;
   endtask
   // Data only counts when the valid pulse is there
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1;
      @(negedge clk_sys);
      d = reg_rvalid_ff ? reg_rdata_ff : 8'hxx;
      reg_rd = 0;
   endtask
endmodule // csx_host

// [csx_pkg.sv]
// Package with offsets, field layout, reset values and gain codes for the sensor register bank
package csx_pkg;
   localparam logic [7:0] CSX_OFS_CONTROL = 8'h2e;
   localparam logic [7:0] CSX_OFS_RESULT = 8'h2f;
   localparam logic [7:0] CSX_OFS_AUX = 8'h30;
   localparam logic [7:0] CSX_RST_CONTROL = 8'h00;
   localparam logic [7:0] CSX_RST_DISPLAY = 8'h00;
   localparam int CSX_TRIM_LSB = 3;
   localparam int CSX_TRIM_W = 5;
   localparam int CSX_GAIN_W = 3;
   localparam logic [4:0] CSX_TRIM_AUTO = 5'h00;
   localparam int CSX_CAP_STEP_FF = 100;
   localparam int CSX_CAP_MAX_FF = 3100;
   localparam logic [2:0] CSX_GAIN_2P8 = 3'h0;
   localparam logic [2:0] CSX_GAIN_6P5 = 3'h1;
   localparam logic [2:0] CSX_GAIN_1P1 = 3'h2;
   localparam logic [2:0] CSX_GAIN_0P5 = 3'h4;
   localparam logic [2:0] CSX_GAIN_0P35 = 3'h6;
   localparam logic [2:0] CSX_GAIN_DEFAULT = 3'h0;

   function automatic logic csx_gain_legal(input logic [2:0] g);
      return (g == CSX_GAIN_2P8) || (g == CSX_GAIN_6P5) || (g == CSX_GAIN_1P1) ||
             (g == CSX_GAIN_0P5) || (g == CSX_GAIN_0P35);
   endfunction
endpackage

// [csx_regs.sv]
// Capacitive sensor control, result display and auxiliary status register bank
`timescale 1ns/100ps
module csx_regs (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Restore-defaults command, one-cycle pulse
   input wire logic set_default,
   // Register access port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_ff,
   output logic reg_rvalid_ff,
   // Sensor control outputs
   output logic [4:0] trim_ff,
   output logic manual_cal_ff,
   output logic [2:0] gain_ff,
   // Calibration result from sensor
   input wire logic [4:0] cal_value,
   input wire logic cal_done,
   input wire logic cal_fail,
   // Status sources
   input wire logic channel_pm,
   input wire logic field_detected,
   input wire logic tx_active,
   input wire logic osc_running,
   input wire logic osc_stable,
   input wire logic rx_enabled,
   input wire logic rx_busy,
   input wire logic peer_detect_active,
   input wire logic collision_avoid_active
);
   logic [7:0] control_ff;
   logic [7:0] result_ff;
   logic [7:0] aux_ff;
   logic [7:0] nxt_rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Control register; only a write to its own offset, reset or set_default changes it
   always_ff @(posedge clk_sys) begin
      if (!rst_n || set_default) begin
         control_ff <= csx_pkg::CSX_RST_CONTROL;
      end else if (reg_wr && reg_addr == csx_pkg::CSX_OFS_CONTROL) begin
         control_ff <= reg_wdata;
      end
   end

   // Decoded copies kept registered so the sensor sees glitch-free levels
   always_ff @(posedge clk_sys) begin
      if (!rst_n || set_default) begin
         trim_ff <= csx_pkg::CSX_TRIM_AUTO;
         manual_cal_ff <= 1'b0;
         gain_ff <= csx_pkg::CSX_GAIN_DEFAULT;
      end else if (reg_wr && reg_addr == csx_pkg::CSX_OFS_CONTROL) begin
         trim_ff <= reg_wdata[7:3];
         manual_cal_ff <= (reg_wdata[7:3] != csx_pkg::CSX_TRIM_AUTO);
         // Illegal codes are software's fault; passed through unchanged
         gain_ff <= reg_wdata[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Result display; bit 0 reserved and reads zero
   always_ff @(posedge clk_sys) begin
      if (!rst_n || set_default) begin
         result_ff <= csx_pkg::CSX_RST_DISPLAY;
      end else begin
         result_ff <= {cal_value, cal_done, cal_fail, 1'b0};
      end
   end

   csx_aux_status u_aux (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .set_default(set_default),
      .channel_pm(channel_pm),
      .field_detected(field_detected),
      .tx_active(tx_active),
      .osc_running(osc_running),
      .osc_stable(osc_stable),
      .rx_enabled(rx_enabled),
      .rx_busy(rx_busy),
      .peer_detect_active(peer_detect_active),
      .collision_avoid_active(collision_avoid_active),
      .aux_ff(aux_ff)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: unmapped offsets read zero
   always_comb begin
      if (reg_addr == csx_pkg::CSX_OFS_CONTROL) begin
         nxt_rdata = control_ff;
      end else if (reg_addr == csx_pkg::CSX_OFS_RESULT) begin
         nxt_rdata = result_ff;
      end else if (reg_addr == csx_pkg::CSX_OFS_AUX) begin
         nxt_rdata = aux_ff;
      end else begin
         nxt_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata_ff <= 8'h00;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= reg_rd;
         if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end
endmodule // csx_regs

// [csx_regs_asserts.sv]
// Assertions on the sensor register bank ports
`timescale 1ns/100ps
module csx_regs_chk (
   input wire logic clk_sys, rst_n, set_default, reg_wr, reg_rd,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata_ff,
   input wire logic reg_rvalid_ff, manual_cal_ff,
   input wire logic [4:0] trim_ff,
   input wire logic [2:0] gain_ff
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_WR: assert property (reg_wr && reg_addr == 8'h2e && !set_default |=>
      {trim_ff, gain_ff} == $past(reg_wdata)) else $error("write lost");
   AST_MAN: assert property (manual_cal_ff == (trim_ff != 5'h0)) else $error("mode");
   AST_CLR: assert property (set_default |=> {trim_ff, gain_ff, manual_cal_ff} == 9'h000)
      else $error("clear");
   AST_HOLD: assert property (!set_default && !(reg_wr && reg_addr == 8'h2e) |=>
      $stable({trim_ff, gain_ff})) else $error("control moved");
   AST_RV: assert property (reg_rd |=> reg_rvalid_ff) else $error("no valid");
   AST_RVP: assert property (!reg_rd |=> !reg_rvalid_ff) else $error("valid too long");
   AST_RDC: assert property (reg_rd && reg_addr == 8'h2e |=>
      reg_rdata_ff == $past({trim_ff, gain_ff})) else $error("readback");
   AST_UNM: assert property (reg_rd && reg_addr > 8'h30 |=> reg_rdata_ff == 8'h00)
      else $error("unmapped");
   AST_KEEP: assert property (!reg_rd |=> $stable(reg_rdata_ff)) else $error("rdata");
endmodule // csx_regs_chk
bind csx_regs csx_regs_chk i_chk (.clk_sys, .rst_n, .set_default, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata_ff, .reg_rvalid_ff, .manual_cal_ff, .trim_ff, .gain_ff);

// [csx_regs_tb_top.sv]
// Self-checking bench for the sensor register bank
`timescale 1ns/100ps
module csx_regs_tb_top;
   logic clk_sys = 0, rst_n = 0, set_default = 0, reg_wr, reg_rd, reg_rvalid_ff, manual_cal_ff;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, d;
   logic [4:0] trim_ff;
   logic [2:0] gain_ff;
   logic [8:0] s = 0;
   logic [6:0] cal = 0;
   logic [7:0] ct [5] = '{8'h00, 8'h09, 8'h82, 8'hf4, 8'hfe};
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   always #25 clk_sys = ~clk_sys;
   csx_host i_host (.clk_sys, .reg_rvalid_ff, .reg_rdata_ff, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata);
   csx_regs i_dut (.clk_sys, .rst_n, .set_default, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata_ff, .reg_rvalid_ff, .trim_ff, .manual_cal_ff, .gain_ff, .cal_value(cal[6:2]),
      .cal_done(cal[1]), .cal_fail(cal[0]), .channel_pm(s[8]), .field_detected(s[7]),
      .tx_active(s[6]), .osc_running(s[5]), .osc_stable(s[4]), .rx_enabled(s[3]),
      .rx_busy(s[2]), .peer_detect_active(s[1]), .collision_avoid_active(s[0]));
   task automatic chk(input logic [8:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, exp);
      i_host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic close_out;
      $display("mismatches %0d checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out;
      end
   end
   initial begin
      repeat (3) @(negedge clk_sys);
      rst_n = 1;
      rchk(8'h2e, 8'h00);
      rchk(8'h2f, 8'h00);
      rchk(8'h30, 8'h00);
      foreach (ct[k]) begin
         i_host.wr(8'h2e, ct[k]);
         rchk(8'h2e, ct[k]);
         chk({trim_ff, manual_cal_ff, gain_ff}, {ct[k][7:3], ct[k][7:3] != 0, ct[k][2:0]});
      end
      @(negedge clk_sys);
      set_default = 1;
      @(negedge clk_sys);
      set_default = 0;
      chk({trim_ff, manual_cal_ff, gain_ff}, 9'h000);
      cal = 7'h2a;
      rchk(8'h2f, 8'h54);
      i_host.wr(8'h2f, 8'h00);
      rchk(8'h2f, 8'h54);
      cal = 7'h7d;
      rchk(8'h2f, 8'hfa);
      for (int i = 0; i < 10; i++) begin
         s = (i == 9) ? 9'h030 : 9'h001 << i;
         rchk(8'h30, {s[8:6], s[5] & s[4], s[3:0]});
      end
      i_host.wr(8'h30, 8'hff);
      rchk(8'h30, 8'h10);
      rchk(8'h31, 8'h00);
      close_out;
   end
endmodule // csx_regs_tb_top
